// File: common/timer_pair_map.vh
// Register addresses, field positions, codes and reset values of the timers
`ifndef TIMER_PAIR_MAP_VH
`define TIMER_PAIR_MAP_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_CONTROL_STATUS 8'h88
`define ADDR_MODE_CONFIG 8'h89
`define ADDR_A_LOW 8'h8a
`define ADDR_B_LOW 8'h8b
`define ADDR_A_HIGH 8'h8c
`define ADDR_B_HIGH 8'h8d
`define ADDR_CLOCK_CONFIG 8'h8e

// ----------------------------------------------------------------------
// Control/status bit positions
// ----------------------------------------------------------------------
`define CS_B_FLAG 7
`define CS_B_RUN 6
`define CS_A_FLAG 5
`define CS_A_RUN 4
`define CS_XB_FLAG 3
`define CS_XB_TYPE 2
`define CS_XA_FLAG 1
`define CS_XA_TYPE 0

// ----------------------------------------------------------------------
// Mode configuration fields
// ----------------------------------------------------------------------
`define MC_B_GATE 7
`define MC_B_CNTSEL 6
`define MC_B_MODE_HI 5
`define MC_B_MODE_LO 4
`define MC_A_GATE 3
`define MC_A_CNTSEL 2
`define MC_A_MODE_HI 1
`define MC_A_MODE_LO 0

// ----------------------------------------------------------------------
// Clock configuration fields
// ----------------------------------------------------------------------
`define CC_B_CLKSEL 3
`define CC_A_CLKSEL 2
`define CC_PSC_HI 1
`define CC_PSC_LO 0
`define CC_USED_MASK 8'h0f

// ----------------------------------------------------------------------
// Codes, divider limits and reset values
// ----------------------------------------------------------------------
`define MODE_13BIT 2'b00
`define MODE_16BIT 2'b01
`define MODE_RELOAD 2'b10
`define MODE_SPLIT 2'b11
`define PSC_DIV12 2'b00
`define PSC_DIV4 2'b01
`define PSC_DIV48 2'b10
`define PSC_EXT8 2'b11
`define PSC_LIM12 6'h0b
`define PSC_LIM4 6'h03
`define PSC_LIM48 6'h2f
`define EXT_LIM8 3'h7
`define RESET_BYTE 8'h00

`endif

// File: verilog/input_sync_edge.v
// Two-stage input synchroniser with edge detection per bit
`timescale 1ns/1ps
`default_nettype none

module input_sync_edge #(
  parameter WIDTH = 5
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] level_o,
  output wire [WIDTH-1:0] fall_o,
  output wire [WIDTH-1:0] rise_o
);

  // ----------------------------------------------------------------------
  // Per-bit synchroniser
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      reg prev_reg;
      // First stage feeds only the second; compare stages two and three
      always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
          prev_reg <= 1'b1;
        end else begin
          meta_reg <= async_i[gi];
          sync_reg <= meta_reg;
          prev_reg <= sync_reg;
        end
      end
      assign level_o[gi] = sync_reg;
      assign fall_o[gi] = prev_reg & ~sync_reg;
      assign rise_o[gi] = ~prev_reg & sync_reg;
    end
  endgenerate

endmodule

`default_nettype wire

// File: verilog/dual_timer_counter.v
// Two 16-bit counter/timers with shared control/status register
`timescale 1ns/1ps
`default_nettype none
`include "timer_pair_map.vh"

module dual_timer_counter (
  input wire mclk_i,
  input wire rst_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  output reg [7:0] sfr_rdata_o,
  input wire timer_a_count_pin_i,
  input wire timer_b_count_pin_i,
  input wire ext_gate_input_a_i,
  input wire ext_gate_input_b_i,
  input wire ext_clk_i,
  input wire gate_a_polarity_i,
  input wire gate_b_polarity_i,
  input wire timer_a_irq_enable_i,
  input wire timer_b_irq_enable_i,
  input wire timer_a_vector_i,
  input wire timer_b_vector_i,
  input wire ext_a_vector_i,
  input wire ext_b_vector_i,
  output reg timer_a_irq_o,
  output reg timer_b_irq_o,
  output reg ext_irq_a_o,
  output reg ext_irq_b_o,
  output reg timer_b_overflow_o
);

  // ----------------------------------------------------------------------
  // Count step for modes 0 to 2; returns {overflow, high, low}
  // ----------------------------------------------------------------------
  function [16:0] count_step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    reg [13:0] c13;
    reg [16:0] c16;
    reg [8:0] c8;
    begin
      c13 = {1'b0, hi, lo[4:0]} + 14'd1;
      c16 = {1'b0, hi, lo} + 17'd1;
      c8 = {1'b0, lo} + 9'd1;
      case (mode)
        // Upper three low-byte bits are left alone
        `MODE_13BIT: count_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
        `MODE_16BIT: count_step = c16;
        `MODE_RELOAD: count_step = {c8[8], hi, c8[8] ? hi : c8[7:0]};
        default: count_step = {1'b0, hi, lo};
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  wire [4:0] pin_level;
  wire [4:0] pin_fall;
  wire [4:0] pin_rise;

  // Bits: 0 count A, 1 count B, 2 gate A, 3 gate B, 4 external clock
  input_sync_edge #(
    .WIDTH(5)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i({ext_clk_i, ext_gate_input_b_i, ext_gate_input_a_i,
      timer_b_count_pin_i, timer_a_count_pin_i}),
    .level_o(pin_level),
    .fall_o(pin_fall),
    .rise_o(pin_rise)
  );

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg timer_a_overflow_flag_reg;
  reg timer_b_overflow_flag_reg;
  reg timer_a_run_reg;
  reg timer_b_run_reg;
  reg ext_irq_a_flag_reg;
  reg ext_irq_b_flag_reg;
  reg ext_irq_a_type_reg;
  reg ext_irq_b_type_reg;
  reg [7:0] timer_mode_config_reg;
  reg [3:0] timer_clock_config_reg;
  reg [7:0] timer_a_low_byte_reg;
  reg [7:0] timer_a_high_byte_reg;
  reg [7:0] timer_b_low_byte_reg;
  reg [7:0] timer_b_high_byte_reg;
  reg [5:0] psc_cnt_reg;
  reg [2:0] ext_div_reg;

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  wire [1:0] mode_a;
  wire [1:0] mode_b;
  wire [1:0] prescale_field;
  wire split_a;
  wire gate_active_a;
  wire gate_active_b;
  wire timer_a_enabled;
  wire timer_b_enabled;

  assign mode_a = timer_mode_config_reg[`MC_A_MODE_HI:`MC_A_MODE_LO];
  assign mode_b = timer_mode_config_reg[`MC_B_MODE_HI:`MC_B_MODE_LO];
  assign prescale_field = timer_clock_config_reg[`CC_PSC_HI:`CC_PSC_LO];
  assign split_a = (mode_a == `MODE_SPLIT);

  // Polarity one means active high
  assign gate_active_a = (pin_level[2] == gate_a_polarity_i);
  assign gate_active_b = (pin_level[3] == gate_b_polarity_i);

  // Run with gate off, or with gate on and input active
  assign timer_a_enabled = timer_a_run_reg &
    (~timer_mode_config_reg[`MC_A_GATE] | gate_active_a);
  // B ignores its run bit while A is split; mode 3 then stops it
  assign timer_b_enabled = split_a ? (mode_b != `MODE_SPLIT) :
    (timer_b_run_reg &
    (~timer_mode_config_reg[`MC_B_GATE] | gate_active_b));

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  reg [5:0] psc_limit;
  reg psc_tick;
  wire ext_tick;

  // External clock is only seen through the synchroniser, hence div 8
  assign ext_tick = pin_fall[4] & (ext_div_reg == `EXT_LIM8);

  // Divider limit and tick from the prescale field
  always @* begin
    case (prescale_field)
      `PSC_DIV12: psc_limit = `PSC_LIM12;
      `PSC_DIV4: psc_limit = `PSC_LIM4;
      `PSC_DIV48: psc_limit = `PSC_LIM48;
      default: psc_limit = `PSC_LIM12;
    endcase
    if (prescale_field == `PSC_EXT8) begin
      psc_tick = ext_tick;
    end else begin
      psc_tick = (psc_cnt_reg >= psc_limit);
    end
  end

  // Free-running dividers; >= limit recovers from a field change
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      psc_cnt_reg <= 6'h00;
      ext_div_reg <= 3'h0;
    end else begin
      if (psc_cnt_reg >= psc_limit) begin
        psc_cnt_reg <= 6'h00;
      end else begin
        psc_cnt_reg <= psc_cnt_reg + 6'h01;
      end
      if (pin_fall[4]) begin
        ext_div_reg <= ext_div_reg + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Count sources
  // ----------------------------------------------------------------------
  wire tick_a;
  wire tick_a_high;
  wire tick_b;

  // A: pin falls, or system clock, or prescaled clock
  assign tick_a = timer_mode_config_reg[`MC_A_CNTSEL] ? pin_fall[0] :
    (timer_clock_config_reg[`CC_A_CLKSEL] | psc_tick);
  // Split high byte never counts the pin
  assign tick_a_high = timer_clock_config_reg[`CC_A_CLKSEL] | psc_tick;
  // B loses its pin while A is split
  assign tick_b = (timer_mode_config_reg[`MC_B_CNTSEL] & ~split_a) ?
    pin_fall[1] :
    (timer_clock_config_reg[`CC_B_CLKSEL] | psc_tick);

  // ----------------------------------------------------------------------
  // Count next values
  // ----------------------------------------------------------------------
  reg [7:0] a_low_next;
  reg [7:0] a_high_next;
  reg [7:0] b_low_next;
  reg [7:0] b_high_next;
  reg ovf_a;
  reg ovf_a_high;
  reg ovf_b;
  reg [16:0] a_step;
  reg [16:0] b_step;
  reg [8:0] a_lo_inc;
  reg [8:0] a_hi_inc;
  reg wr_a_low;
  reg wr_a_high;
  reg wr_b_low;
  reg wr_b_high;

  // Hardware step first, then software writes override
  always @* begin
    a_step = count_step(mode_a, timer_a_high_byte_reg, timer_a_low_byte_reg);
    b_step = count_step(mode_b, timer_b_high_byte_reg, timer_b_low_byte_reg);
    a_lo_inc = {1'b0, timer_a_low_byte_reg} + 9'd1;
    a_hi_inc = {1'b0, timer_a_high_byte_reg} + 9'd1;
    wr_a_low = sfr_wr_i & (sfr_addr_i == `ADDR_A_LOW);
    wr_a_high = sfr_wr_i & (sfr_addr_i == `ADDR_A_HIGH);
    wr_b_low = sfr_wr_i & (sfr_addr_i == `ADDR_B_LOW);
    wr_b_high = sfr_wr_i & (sfr_addr_i == `ADDR_B_HIGH);
    a_low_next = timer_a_low_byte_reg;
    a_high_next = timer_a_high_byte_reg;
    b_low_next = timer_b_low_byte_reg;
    b_high_next = timer_b_high_byte_reg;
    ovf_a = 1'b0;
    ovf_a_high = 1'b0;
    ovf_b = 1'b0;
    if (split_a) begin
      // Two independent 8-bit counters
      if (timer_a_enabled & tick_a) begin
        a_low_next = a_lo_inc[7:0];
        ovf_a = a_lo_inc[8];
      end
      if (timer_b_run_reg & tick_a_high) begin
        a_high_next = a_hi_inc[7:0];
        ovf_a_high = a_hi_inc[8];
      end
    end else if (timer_a_enabled & tick_a) begin
      a_high_next = a_step[15:8];
      a_low_next = a_step[7:0];
      ovf_a = a_step[16];
    end
    // Mode 3 of B holds via the default step
    if (timer_b_enabled & tick_b) begin
      b_high_next = b_step[15:8];
      b_low_next = b_step[7:0];
      ovf_b = b_step[16];
    end
    if (wr_a_low) begin
      a_low_next = sfr_wdata_i;
    end
    if (wr_a_high) begin
      a_high_next = sfr_wdata_i;
    end
    if (wr_b_low) begin
      b_low_next = sfr_wdata_i;
    end
    if (wr_b_high) begin
      b_high_next = sfr_wdata_i;
    end
  end

  // ----------------------------------------------------------------------
  // Flag next values
  // ----------------------------------------------------------------------
  reg wr_cs;
  reg set_tf_a;
  reg set_tf_b;
  reg set_ie_a;
  reg set_ie_b;
  reg tf_a_next;
  reg tf_b_next;
  reg ie_a_next;
  reg ie_b_next;
  reg edge_a;
  reg edge_b;

  // Hardware set always beats a same-cycle clear
  always @* begin
    wr_cs = sfr_wr_i & (sfr_addr_i == `ADDR_CONTROL_STATUS);
    set_tf_a = ovf_a;
    // B's own overflow is muted while A is split
    set_tf_b = split_a ? ovf_a_high : ovf_b;
    edge_a = gate_a_polarity_i ? pin_rise[2] : pin_fall[2];
    edge_b = gate_b_polarity_i ? pin_rise[3] : pin_fall[3];
    set_ie_a = edge_a;
    set_ie_b = edge_b;
    tf_a_next = timer_a_overflow_flag_reg & ~timer_a_vector_i;
    tf_b_next = timer_b_overflow_flag_reg & ~timer_b_vector_i;
    ie_a_next = ext_irq_a_flag_reg & ~ext_a_vector_i;
    ie_b_next = ext_irq_b_flag_reg & ~ext_b_vector_i;
    if (wr_cs) begin
      tf_a_next = sfr_wdata_i[`CS_A_FLAG];
      tf_b_next = sfr_wdata_i[`CS_B_FLAG];
      ie_a_next = sfr_wdata_i[`CS_XA_FLAG];
      ie_b_next = sfr_wdata_i[`CS_XB_FLAG];
    end
    tf_a_next = tf_a_next | set_tf_a;
    tf_b_next = tf_b_next | set_tf_b;
    if (ext_irq_a_type_reg) begin
      ie_a_next = ie_a_next | set_ie_a;
    end else begin
      ie_a_next = gate_active_a;
    end
    if (ext_irq_b_type_reg) begin
      ie_b_next = ie_b_next | set_ie_b;
    end else begin
      ie_b_next = gate_active_b;
    end
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  // Run bits change only the enable; counts are never cleared here
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_a_overflow_flag_reg <= 1'b0;
      timer_b_overflow_flag_reg <= 1'b0;
      timer_a_run_reg <= 1'b0;
      timer_b_run_reg <= 1'b0;
      ext_irq_a_flag_reg <= 1'b0;
      ext_irq_b_flag_reg <= 1'b0;
      ext_irq_a_type_reg <= 1'b0;
      ext_irq_b_type_reg <= 1'b0;
      timer_mode_config_reg <= `RESET_BYTE;
      timer_clock_config_reg <= 4'h0;
      timer_a_low_byte_reg <= `RESET_BYTE;
      timer_a_high_byte_reg <= `RESET_BYTE;
      timer_b_low_byte_reg <= `RESET_BYTE;
      timer_b_high_byte_reg <= `RESET_BYTE;
    end else begin
      timer_a_overflow_flag_reg <= tf_a_next;
      timer_b_overflow_flag_reg <= tf_b_next;
      ext_irq_a_flag_reg <= ie_a_next;
      ext_irq_b_flag_reg <= ie_b_next;
      timer_a_low_byte_reg <= a_low_next;
      timer_a_high_byte_reg <= a_high_next;
      timer_b_low_byte_reg <= b_low_next;
      timer_b_high_byte_reg <= b_high_next;
      if (wr_cs) begin
        timer_a_run_reg <= sfr_wdata_i[`CS_A_RUN];
        timer_b_run_reg <= sfr_wdata_i[`CS_B_RUN];
        ext_irq_a_type_reg <= sfr_wdata_i[`CS_XA_TYPE];
        ext_irq_b_type_reg <= sfr_wdata_i[`CS_XB_TYPE];
      end
      if (sfr_wr_i & (sfr_addr_i == `ADDR_MODE_CONFIG)) begin
        timer_mode_config_reg <= sfr_wdata_i;
      end
      if (sfr_wr_i & (sfr_addr_i == `ADDR_CLOCK_CONFIG)) begin
        timer_clock_config_reg <= sfr_wdata_i[`CC_B_CLKSEL:`CC_PSC_LO];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  reg [7:0] read_mux;

  // Unmapped addresses read zero
  always @* begin
    case (sfr_addr_i)
      `ADDR_CONTROL_STATUS: read_mux = {timer_b_overflow_flag_reg,
        timer_b_run_reg, timer_a_overflow_flag_reg, timer_a_run_reg,
        ext_irq_b_flag_reg, ext_irq_b_type_reg, ext_irq_a_flag_reg,
        ext_irq_a_type_reg};
      `ADDR_MODE_CONFIG: read_mux = timer_mode_config_reg;
      `ADDR_CLOCK_CONFIG: read_mux = {4'h0, timer_clock_config_reg};
      `ADDR_A_LOW: read_mux = timer_a_low_byte_reg;
      `ADDR_A_HIGH: read_mux = timer_a_high_byte_reg;
      `ADDR_B_LOW: read_mux = timer_b_low_byte_reg;
      `ADDR_B_HIGH: read_mux = timer_b_high_byte_reg;
      default: read_mux = `RESET_BYTE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  // Interrupt lines trail their flags by one cycle
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_rdata_o <= `RESET_BYTE;
      timer_a_irq_o <= 1'b0;
      timer_b_irq_o <= 1'b0;
      ext_irq_a_o <= 1'b0;
      ext_irq_b_o <= 1'b0;
      timer_b_overflow_o <= 1'b0;
    end else begin
      if (sfr_rd_i) begin
        sfr_rdata_o <= read_mux;
      end
      timer_a_irq_o <= timer_a_overflow_flag_reg & timer_a_irq_enable_i;
      timer_b_irq_o <= timer_b_overflow_flag_reg & timer_b_irq_enable_i;
      ext_irq_a_o <= ext_irq_a_flag_reg;
      ext_irq_b_o <= ext_irq_b_flag_reg;
      // Baud and conversion pulse follows B even while A is split
      timer_b_overflow_o <= ovf_b;
    end
  end

endmodule

`default_nettype wire

// File: testbench/pin_source.sv
// Far-side model: count pins, gate inputs and external clock
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input wire logic mclk_i,
  output logic [1:0] count_pin_o,
  output logic [1:0] gate_o,
  output logic ext_clk_o
);
  // ------
  // Count pins idle high, gate inputs low; the clock pin stands still
  // ------
  initial begin
    count_pin_o = 2'b11;
    gate_o = 2'b00;
    ext_clk_o = 1'b1;
  end

  // Falling edges, each level held for hold cycles (hold of 2 at least)
  task pulse(input int which, input int n, input int hold);
    repeat (n) begin
      @(posedge mclk_i);
      count_pin_o[which] <= 1'b0;
      repeat (hold) @(posedge mclk_i);
      count_pin_o[which] <= 1'b1;
      repeat (hold - 1) @(posedge mclk_i);
    end
    repeat (4) @(posedge mclk_i);
  endtask

  // Gate level change, then time for the synchroniser to settle
  task set_gate(input int which, input logic lvl);
    @(posedge mclk_i);
    gate_o[which] <= lvl;
    repeat (6) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// File: testbench/dual_timer_counter_chk.sv
// Port-level assertions for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic ext_gate_input_a_i,
  input wire logic ext_gate_input_b_i,
  input wire logic gate_a_polarity_i,
  input wire logic gate_b_polarity_i,
  input wire logic timer_a_irq_enable_i,
  input wire logic timer_b_irq_enable_i,
  input wire logic timer_a_irq_o,
  input wire logic timer_b_irq_o,
  input wire logic ext_irq_a_o,
  input wire logic ext_irq_b_o
);
  logic [7:0] mode_reg;
  logic [7:0] clk_reg;
  logic [1:0] type_reg;

  // ------
  // Shadows of fields that only software changes
  // ------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg <= 8'h00;
      clk_reg <= 8'h00;
      type_reg <= 2'b00;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == 8'h89) mode_reg <= sfr_wdata_i;
      if (sfr_addr_i == 8'h8e) clk_reg <= sfr_wdata_i;
      if (sfr_addr_i == 8'h88) type_reg <= {sfr_wdata_i[2], sfr_wdata_i[0]};
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Six quiet cycles cover the sync stages plus the output register
  sequence s_a_active;
    (!type_reg[0] && !sfr_wr_i &&
     ext_gate_input_a_i == gate_a_polarity_i)[*6];
  endsequence
  sequence s_b_active;
    (!type_reg[1] && !sfr_wr_i &&
     ext_gate_input_b_i == gate_b_polarity_i)[*6];
  endsequence

  property p_unmapped;
    sfr_rd_i && (sfr_addr_i < 8'h88 || sfr_addr_i > 8'h8e)
      |=> sfr_rdata_o == 8'h00;
  endproperty
  property p_hold;
    !sfr_rd_i |=> $stable(sfr_rdata_o);
  endproperty
  property p_mode_rd;
    sfr_rd_i && sfr_addr_i == 8'h89 |=> sfr_rdata_o == $past(mode_reg);
  endproperty
  property p_clk_rd;
    sfr_rd_i && sfr_addr_i == 8'h8e
      |=> sfr_rdata_o == ($past(clk_reg) & 8'h0f);
  endproperty
  property p_a_irq_off;
    !timer_a_irq_enable_i |=> !timer_a_irq_o;
  endproperty
  property p_b_irq_off;
    !timer_b_irq_enable_i |=> !timer_b_irq_o;
  endproperty
  property p_a_lvl_on;
    s_a_active |-> ext_irq_a_o;
  endproperty
  property p_b_lvl_on;
    s_b_active |-> ext_irq_b_o;
  endproperty

  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_hold: assert property (p_hold)
    else $error("read data moved without a read");
  a_mode_rd: assert property (p_mode_rd)
    else $error("mode config read wrong");
  a_clk_rd: assert property (p_clk_rd)
    else $error("clock config read wrong");
  a_a_irq_off: assert property (p_a_irq_off)
    else $error("timer a irq while disabled");
  a_b_irq_off: assert property (p_b_irq_off)
    else $error("timer b irq while disabled");
  a_a_lvl_on: assert property (p_a_lvl_on)
    else $error("level flag a not following input");
  a_b_lvl_on: assert property (p_b_lvl_on)
    else $error("level flag b not following input");
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [3:0] vec = 4'h0;
  logic [1:0] pol = 2'b01;
  logic [1:0] irq_en = 2'b00;
  wire [7:0] sfr_rdata_o;
  wire [1:0] pin;
  wire [1:0] gate;
  wire ext_clk, ta_irq, tb_irq, xa_irq, xb_irq, b_ovf;
  int fail_count = 0;
  int num_checks = 0;
  int ovf_n = 0;
  logic [31:0] seed = 32'd69;
  logic [31:0] r;
  logic [7:0] v, hi, lo, run, flg;
  int t, m, k, c;
  logic f;

  always #5 mclk_i = ~mclk_i;

  // Timer B overflow pulses, counted while they stand
  always @(posedge mclk_i) if (b_ovf) ovf_n++;

  pin_source i_pin_source (.mclk_i(mclk_i), .count_pin_o(pin),
    .gate_o(gate), .ext_clk_o(ext_clk));

  dual_timer_counter i_dual_timer_counter (
    .mclk_i(mclk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .timer_a_count_pin_i(pin[0]),
    .timer_b_count_pin_i(pin[1]), .ext_gate_input_a_i(gate[0]),
    .ext_gate_input_b_i(gate[1]), .ext_clk_i(ext_clk),
    .gate_a_polarity_i(pol[0]), .gate_b_polarity_i(pol[1]),
    .timer_a_irq_enable_i(irq_en[0]), .timer_b_irq_enable_i(irq_en[1]),
    .timer_a_vector_i(vec[0]), .timer_b_vector_i(vec[1]),
    .ext_a_vector_i(vec[2]), .ext_b_vector_i(vec[3]),
    .timer_a_irq_o(ta_irq), .timer_b_irq_o(tb_irq), .ext_irq_a_o(xa_irq),
    .ext_irq_b_o(xb_irq), .timer_b_overflow_o(b_ovf));

  // ------
  // Helpers
  // ------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Level-type flag bits as the gate inputs stand now
  function automatic logic [7:0] lvl();
    return {4'h0, gate[1] == pol[1], 1'b0, gate[0] == pol[0], 1'b0};
  endfunction

  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sfr_wr_i <= 1'b1;
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    @(posedge mclk_i);
    sfr_wr_i <= 1'b0;
  endtask

  // Data lands one edge after the read is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    sfr_rd_i <= 1'b1;
    sfr_addr_i <= a;
    @(posedge mclk_i);
    sfr_rd_i <= 1'b0;
    #1 d = sfr_rdata_o;
  endtask

  task automatic vector(input logic [3:0] msk);
    @(posedge mclk_i);
    vec <= msk;
    @(posedge mclk_i);
    vec <= 4'h0;
    repeat (2) @(posedge mclk_i);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog: the whole run needs a few thousand cycles at most
  initial begin
    #200000;
    fail_count++;
    summarize();
  end

  // ------
  // Main sequence
  // ------
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    for (k = 8'h88; k <= 8'h8e; k++) begin
      rd(k[7:0], v);
      chk("reset", v, k == 8'h88 ? lvl() : 8'h00);
    end
    $display("test reset done");
    // Written last so a split A cannot disturb the B bytes under test
    for (k = 8'h8e; k >= 8'h80; k--) begin
      r = xs();
      wr(k[7:0], r[7:0]);
      rd(k[7:0], v);
      chk("reg", v, k < 8'h89 ? 8'h00 : (k == 8'h8e ? r[7:0] & 8'h0f
          : r[7:0]));
      if (k == 8'h89) k = 8'h81;
    end
    $display("test registers done");
    irq_en <= 2'b11;
    for (t = 0; t < 2; t++) begin
      for (m = 0; m < 3; m++) begin
        r = xs();
        hi = (m == 2) ? r[15:8] : 8'hff;
        lo = 8'hff - {6'h00, r[1:0]};
        run = t ? 8'h40 : 8'h10;
        flg = t ? 8'h80 : 8'h20;
        // Gate and pin counting selected, mode m
        wr(8'h89, t ? {2'b11, m[1:0], 4'h0} : {4'h0, 2'b11, m[1:0]});
        wr(8'h8a + t[7:0], lo);
        wr(8'h8c + t[7:0], hi);
        i_pin_source.set_gate(t, ~pol[t]);
        wr(8'h88, run);
        i_pin_source.pulse(t, 2, 2);
        i_pin_source.set_gate(t, pol[t]);
        i_pin_source.pulse(t, 4, 2 + r[2]);
        f = 1'b0;
        for (k = 0; k < 4; k++) begin
          if (m == 2) begin
            lo = lo + 8'h01;
            if (lo == 8'h00) begin
              f = 1'b1;
              lo = hi;
            end
          end else begin
            c = (m == 0) ? {hi, lo[4:0]} + 1 : {hi, lo} + 1;
            f = f | ((m == 0) ? c[12:0] == 0 : c[15:0] == 0);
            hi = (m == 0) ? c[12:5] : c[15:8];
            lo = (m == 0) ? {lo[7:5], c[4:0]} : c[7:0];
          end
        end
        rd(8'h8a + t[7:0], v);
        chk("low", v, lo);
        rd(8'h8c + t[7:0], v);
        chk("high", v, hi);
        rd(8'h88, v);
        chk("flags", v, run | (f ? flg : 8'h00) | lvl());
        chk("irq", {7'h0, t ? tb_irq : ta_irq}, {7'h0, f});
        vector(t ? 4'h2 : 4'h1);
        rd(8'h88, v);
        chk("vector", v, run | lvl());
        wr(8'h88, 8'h00);
        $display("test count timer %0d mode %0d done", t, m);
      end
    end
    i_pin_source.set_gate(0, ~pol[0]);
    i_pin_source.set_gate(1, ~pol[1]);
    wr(8'h88, 8'h05);
    rd(8'h88, v);
    chk("edge idle", v, 8'h05);
    i_pin_source.set_gate(0, pol[0]);
    i_pin_source.set_gate(1, pol[1]);
    rd(8'h88, v);
    chk("edge set", v, 8'h0f);
    vector(4'hc);
    rd(8'h88, v);
    chk("edge clear", v, 8'h05);
    chk("edge out", {6'h0, xb_irq, xa_irq}, 8'h00);
    $display("test edge flags done");
    // Split A: B runs from its mode alone and only pulses its overflow
    wr(8'h88, 8'h00);
    wr(8'h8e, 8'h0c);
    wr(8'h8b, 8'hff);
    wr(8'h8d, 8'hff);
    c = ovf_n;
    wr(8'h89, 8'h13);
    rd(8'h88, v);
    chk("split flag", v, lvl());
    chk("split pulse", 8'(ovf_n - c), 8'h01);
    wr(8'h89, 8'h33);
    wr(8'h8b, 8'h5a);
    repeat (4) @(posedge mclk_i);
    rd(8'h8b, v);
    chk("split stop", v, 8'h5a);
    // A high byte wraps on the next clock and raises B's flag
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h40);
    rd(8'h88, v);
    chk("split high", v, 8'hc0 | lvl());
    wr(8'h88, 8'h00);
    $display("test split done");
    // A on the divide-by-four clock for 82 running edges, so 20 or 21 counts
    wr(8'h8e, 8'h01);
    wr(8'h89, 8'h01);
    wr(8'h8a, 8'h00);
    wr(8'h8c, 8'h00);
    wr(8'h88, 8'h10);
    repeat (80) @(posedge mclk_i);
    wr(8'h88, 8'h00);
    rd(8'h8a, v);
    chk("prescale", {7'h0, v == 8'h14 || v == 8'h15}, 8'h01);
    $display("test prescale done");
    summarize();
  end
endmodule

bind dual_timer_counter dual_timer_counter_chk i_dual_timer_counter_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
  .sfr_rdata_o(sfr_rdata_o), .ext_gate_input_a_i(ext_gate_input_a_i),
  .ext_gate_input_b_i(ext_gate_input_b_i),
  .gate_a_polarity_i(gate_a_polarity_i),
  .gate_b_polarity_i(gate_b_polarity_i),
  .timer_a_irq_enable_i(timer_a_irq_enable_i),
  .timer_b_irq_enable_i(timer_b_irq_enable_i),
  .timer_a_irq_o(timer_a_irq_o), .timer_b_irq_o(timer_b_irq_o),
  .ext_irq_a_o(ext_irq_a_o), .ext_irq_b_o(ext_irq_b_o));
`default_nettype wire
